//--- core/flash_access_pkg.sv
package flash_access_pkg;
    // Command-space addresses
    localparam logic [7:0] ADDR_CTRL_LO = 8'h00;
    localparam logic [7:0] ADDR_CTRL_HI = 8'h01;
    localparam logic [7:0] ADDR_CLASS = 8'h3e;
    localparam logic [7:0] ADDR_BLOCK = 8'h3f;
    localparam logic [7:0] ADDR_WIN_BASE = 8'h40;
    localparam logic [7:0] ADDR_WIN_LAST = 8'h5f;
    localparam logic [7:0] ADDR_CKSUM = 8'h60;
    localparam logic [7:0] ADDR_BAC = 8'h61;

    // Window geometry and checksum
    localparam int WIN_BYTES = 32;
    localparam logic [7:0] CKSUM_BASE = 8'hff;

    // Control subcommands
    localparam logic [15:0] SUB_SEAL = 16'h0020;
    localparam logic [15:0] SUB_RESET = 16'h0041;
    localparam logic [15:0] SUB_BOOT = 16'h0f00;

    // Block-select values in information-block mode, and the BAC value for general access
    localparam logic [7:0] INFO_A = 8'h01;
    localparam logic [7:0] INFO_C = 8'h03;
    localparam logic [7:0] BAC_GENERAL = 8'h00;

    // Control status bit positions
    localparam int STAT_SS_BIT = 13;
    localparam int STAT_FAS_BIT = 14;
    localparam int STAT_BOOT_BIT = 15;

    // Reset values
    localparam logic [7:0] CLASS_RST = 8'h00;
    localparam logic [7:0] BLOCK_RST = 8'h00;
    localparam logic [7:0] BAC_RST = 8'h00;
    localparam logic [5:0] CNT_RST = 6'h00;

    // Sequencer counts
    localparam logic [5:0] LOAD_LAST = 6'h21;
    localparam logic [5:0] STORE_LAST = 6'h1f;

    typedef enum logic [1:0] {
        SEC_SEALED = 2'b00,
        SEC_OPEN = 2'b01,
        SEC_FULL = 2'b11,
        SEC_BOOT = 2'b10
    } sec_mode_e;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_LOAD = 2'b01,
        SEQ_STORE = 2'b11
    } seq_state_e;
endpackage : flash_access_pkg

//--- core/flash_block_access.sv
`timescale 1ns/10ps
module flash_block_access #(
    parameter logic [7:0] INFO_CLASS = 8'd58,
    parameter logic [7:0] KEY_CLASS = 8'd112,
    parameter logic [7:0] PRIVATE_CLASS_MIN = 8'd104,
    parameter logic [15:0] UNSEAL_KEY0 = 16'h0414,
    parameter logic [15:0] UNSEAL_KEY1 = 16'h3672,
    parameter logic [15:0] FULL_KEY0 = 16'hffff,
    parameter logic [15:0] FULL_KEY1 = 16'hffff
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    output logic [7:0] cmd_rdata,
    output logic busy,
    output logic nv_rd_en,
    output logic nv_wr_en,
    output logic [7:0] nv_class,
    output logic [7:0] nv_block,
    output logic [4:0] nv_offset,
    output logic [7:0] nv_wdata,
    input wire logic [7:0] nv_rdata,
    output logic param_reload,
    output logic sealed_status,
    output logic open_mode,
    output logic full_access_indicator,
    output logic boot_loader_mode
);
    import flash_access_pkg::*;

    // Sealed info access relies on the info class staying public
    if (PRIVATE_CLASS_MIN <= INFO_CLASS) begin : gen_bad_class
        $error("Private classes must lie above the info class");
    end

    sec_mode_e mode_reg;
    seq_state_e seq_reg;
    logic [7:0] class_reg;
    logic [7:0] block_reg;
    logic [7:0] bac_reg;
    logic [7:0] ctrl_lo_reg;
    logic [15:0] key_first_reg;
    logic key_pend_reg;
    logic [15:0] ukey0_reg, ukey1_reg, fkey0_reg, fkey1_reg;
    logic [7:0] win_reg [WIN_BYTES];
    logic win_valid_reg;
    logic [5:0] cnt_reg;
    logic cap_en_reg;
    logic [4:0] cap_idx_reg;
    logic info_a_reg;
    logic [7:0] sum;
    logic [7:0] cksum;
    logic info_mode;
    logic ctrl_stb;
    logic [15:0] ctrl_word;
    logic is_sub;
    logic idle;
    logic win_addr;
    logic load_req;
    logic [7:0] load_class;
    logic [7:0] load_block;
    logic commit_ok;
    logic unseal_hit;
    logic full_hit;

    assign idle = (seq_reg == SEQ_IDLE);
    assign busy = !idle;
    assign win_addr = (cmd_addr >= ADDR_WIN_BASE) &&
                      (cmd_addr <= ADDR_WIN_LAST);
    // Sealed or nonzero control switches to info blocks
    assign info_mode = (mode_reg == SEC_SEALED) || (bac_reg != BAC_GENERAL);
    assign ctrl_stb = cmd_wr && idle && (cmd_addr == ADDR_CTRL_HI);
    assign ctrl_word = {cmd_wdata, ctrl_lo_reg};
    assign is_sub = (ctrl_word == SUB_SEAL) || (ctrl_word == SUB_RESET) ||
                    (ctrl_word == SUB_BOOT);
    // Stored word low byte is sent first, so compare as assembled
    assign unseal_hit = key_pend_reg && (key_first_reg == ukey0_reg) &&
                        (ctrl_word == ukey1_reg);
    assign full_hit = key_pend_reg && (key_first_reg == fkey0_reg) &&
                      (ctrl_word == fkey1_reg);

    // Byte-wise modulo-256 sum of the window
    always_comb begin
        sum = 8'h00;
        for (int i = 0; i < WIN_BYTES; i++) begin
            sum = sum + win_reg[i];
        end
        cksum = CKSUM_BASE - sum;
    end

    // Which segment a block-select write loads
    always_comb begin
        load_req = 1'b0;
        load_class = class_reg;
        load_block = cmd_wdata;
        if (cmd_wr && idle && (cmd_addr == ADDR_BLOCK) &&
            (mode_reg != SEC_BOOT)) begin
            if (info_mode) begin
                // Info block n lives in the info class, segment n-1
                load_req = (cmd_wdata >= INFO_A) && (cmd_wdata <= INFO_C);
                load_class = INFO_CLASS;
                load_block = cmd_wdata - INFO_A;
            end else begin
                load_req = 1'b1;
            end
        end
    end

    // Commit gate: checksum match plus access rights
    always_comb begin
        commit_ok = cmd_wr && idle && (cmd_addr == ADDR_CKSUM) &&
                    win_valid_reg && (cmd_wdata == cksum);
        if (mode_reg == SEC_BOOT) begin
            commit_ok = 1'b0;
        end
        if ((mode_reg == SEC_SEALED) && info_a_reg) begin
            commit_ok = 1'b0;
        end
        if ((nv_class == KEY_CLASS) && (mode_reg != SEC_FULL)) begin
            commit_ok = 1'b0;
        end
        if ((nv_class >= PRIVATE_CLASS_MIN) && (mode_reg == SEC_SEALED)) begin
            commit_ok = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            class_reg <= CLASS_RST;
            block_reg <= BLOCK_RST;
            bac_reg <= BAC_RST;
            ctrl_lo_reg <= 8'h00;
        end else if (cmd_wr && idle) begin
            unique case (cmd_addr)
                ADDR_CTRL_LO: ctrl_lo_reg <= cmd_wdata;
                ADDR_CLASS: begin
                    // Class select not offered while sealed
                    if (mode_reg != SEC_SEALED) begin
                        class_reg <= cmd_wdata;
                    end
                end
                ADDR_BLOCK: block_reg <= cmd_wdata;
                ADDR_BAC: bac_reg <= cmd_wdata;
                default: ;
            endcase
        end
    end

    // Security mode sequencing
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mode_reg <= SEC_SEALED;
            key_pend_reg <= 1'b0;
            key_first_reg <= 16'h0000;
            param_reload <= 1'b0;
        end else begin
            param_reload <= 1'b0;
            if (ctrl_stb) begin
                // Any plain word may open a pair, so a stray word never
                // leaves the host out of step with the pairing
                key_pend_reg <= !is_sub;
                key_first_reg <= ctrl_word;
                if (ctrl_word == SUB_SEAL) begin
                    if (mode_reg != SEC_BOOT) begin
                        mode_reg <= SEC_SEALED;
                    end
                end else if (ctrl_word == SUB_RESET) begin
                    // Sealed stays sealed; boot leaves into sealed
                    param_reload <= 1'b1;
                    if (mode_reg == SEC_BOOT) begin
                        mode_reg <= SEC_SEALED;
                    end
                end else if (ctrl_word == SUB_BOOT) begin
                    if (mode_reg == SEC_FULL) begin
                        mode_reg <= SEC_BOOT;
                    end
                end else if ((mode_reg == SEC_SEALED) && unseal_hit) begin
                    mode_reg <= SEC_OPEN;
                    key_pend_reg <= 1'b0;
                end else if ((mode_reg == SEC_OPEN) && full_hit) begin
                    mode_reg <= SEC_FULL;
                    key_pend_reg <= 1'b0;
                end
            end
        end
    end

    // Key storage, rewritten only by a full-access commit
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ukey0_reg <= UNSEAL_KEY0;
            ukey1_reg <= UNSEAL_KEY1;
            fkey0_reg <= FULL_KEY0;
            fkey1_reg <= FULL_KEY1;
        end else if (commit_ok && (nv_class == KEY_CLASS) &&
                     (nv_block == BLOCK_RST)) begin
            ukey0_reg <= {win_reg[1], win_reg[0]};
            ukey1_reg <= {win_reg[3], win_reg[2]};
            fkey0_reg <= {win_reg[5], win_reg[4]};
            fkey1_reg <= {win_reg[7], win_reg[6]};
        end
    end

    // Load and store sequencer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            seq_reg <= SEQ_IDLE;
            cnt_reg <= CNT_RST;
            nv_class <= CLASS_RST;
            nv_block <= BLOCK_RST;
            info_a_reg <= 1'b0;
        end else begin
            unique case (seq_reg)
                SEQ_IDLE: begin
                    cnt_reg <= CNT_RST;
                    if (load_req) begin
                        seq_reg <= SEQ_LOAD;
                        nv_class <= load_class;
                        nv_block <= load_block;
                        info_a_reg <= info_mode && (cmd_wdata == INFO_A);
                    end else if (commit_ok) begin
                        seq_reg <= SEQ_STORE;
                    end
                end
                SEQ_LOAD: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (cnt_reg == LOAD_LAST) begin
                        seq_reg <= SEQ_IDLE;
                    end
                end
                SEQ_STORE: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (cnt_reg == STORE_LAST) begin
                        seq_reg <= SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    // Memory strobes; read data is taken one cycle after nv_rd_en
    always_ff @(posedge core_clk) begin
        if (srst) begin
            nv_rd_en <= 1'b0;
            nv_wr_en <= 1'b0;
            nv_offset <= 5'h00;
            nv_wdata <= 8'h00;
            cap_en_reg <= 1'b0;
            cap_idx_reg <= 5'h00;
        end else begin
            nv_rd_en <= (seq_reg == SEQ_LOAD) && !cnt_reg[5];
            nv_wr_en <= (seq_reg == SEQ_STORE);
            nv_offset <= cnt_reg[4:0];
            // Whole window goes back; unedited bytes hold stored values
            nv_wdata <= win_reg[cnt_reg[4:0]];
            cap_en_reg <= nv_rd_en;
            cap_idx_reg <= nv_offset;
        end
    end

    // Window contents
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < WIN_BYTES; i++) begin
                win_reg[i] <= 8'h00;
            end
            win_valid_reg <= 1'b0;
        end else begin
            if (cap_en_reg) begin
                win_reg[cap_idx_reg] <= nv_rdata;
            end
            if (load_req) begin
                win_valid_reg <= 1'b0;
            end else if ((seq_reg == SEQ_LOAD) && (cnt_reg == LOAD_LAST)) begin
                win_valid_reg <= 1'b1;
            end else if (mode_reg == SEC_BOOT) begin
                win_valid_reg <= 1'b0;
            end
            if (cmd_wr && idle && win_addr && win_valid_reg) begin
                win_reg[cmd_addr[4:0]] <= cmd_wdata;
            end
        end
    end

    // Read path, one cycle behind cmd_rd
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmd_rdata <= 8'h00;
        end else if (cmd_rd) begin
            cmd_rdata <= 8'h00;
            if (win_addr) begin
                if (win_valid_reg) begin
                    cmd_rdata <= win_reg[cmd_addr[4:0]];
                end
            end else begin
                unique case (cmd_addr)
                    ADDR_CTRL_LO: cmd_rdata <= 8'h00;
                    ADDR_CTRL_HI: begin
                        cmd_rdata <= {boot_loader_mode,
                                      full_access_indicator,
                                      sealed_status, 5'h00};
                    end
                    ADDR_CLASS: cmd_rdata <= class_reg;
                    ADDR_BLOCK: cmd_rdata <= block_reg;
                    ADDR_CKSUM: cmd_rdata <= cksum;
                    ADDR_BAC: cmd_rdata <= bac_reg;
                    default: cmd_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Status reflects the mode register directly
    assign sealed_status = (mode_reg == SEC_SEALED);
    assign full_access_indicator = (mode_reg != SEC_FULL) &&
                                   (mode_reg != SEC_BOOT);
    assign open_mode = (mode_reg == SEC_OPEN);
    assign boot_loader_mode = (mode_reg == SEC_BOOT);
endmodule : flash_block_access

//--- sim/flash_block_access_props.sv
`timescale 1ns/10ps
module flash_block_access_props
    import flash_access_pkg::*;
#(
    parameter logic [7:0] INFO_CLASS = 8'd58,
    parameter logic [7:0] KEY_CLASS = 8'd112,
    parameter logic [7:0] PRIVATE_CLASS_MIN = 8'd104
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_rdata,
    input wire logic busy,
    input wire logic nv_rd_en,
    input wire logic nv_wr_en,
    input wire logic [7:0] nv_class,
    input wire logic [7:0] nv_block,
    input wire logic [4:0] nv_offset,
    input wire logic param_reload,
    input wire logic sealed_status,
    input wire logic open_mode,
    input wire logic full_access_indicator,
    input wire logic boot_loader_mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    rd_busy_a: assert property (nv_rd_en |-> busy)
        else $error("memory read outside a load");
    load_len_a: assert property (nv_rd_en && nv_offset == 5'h1f
        |=> busy ##1 !busy) else $error("load length wrong");
    wr_start_a: assert property ($rose(nv_wr_en)
        |-> nv_offset == 5'h00 && busy) else $error("commit start wrong");
    wr_step_a: assert property (nv_wr_en && nv_offset != 5'h1f
        |=> nv_wr_en && nv_offset == $past(nv_offset) + 5'h01)
        else $error("commit stride wrong");
    commit_end_a: assert property (nv_wr_en && nv_offset == 5'h1f
        |-> ##[1:2] !busy) else $error("commit does not end");
    mode_excl_a: assert property (sealed_status
        |-> !open_mode && full_access_indicator && !boot_loader_mode)
        else $error("sealed flags inconsistent");
    info_ro_a: assert property (nv_wr_en && sealed_status
        |-> !(nv_class == INFO_CLASS && nv_block == 8'h00))
        else $error("info A written while sealed");
    private_ro_a: assert property (nv_wr_en && sealed_status
        |-> nv_class < PRIVATE_CLASS_MIN) else $error("private write sealed");
    key_guard_a: assert property (nv_wr_en && nv_class == KEY_CLASS
        |-> !full_access_indicator && !boot_loader_mode)
        else $error("key write outside full access");
    boot_idle_a: assert property (boot_loader_mode
        |-> !nv_wr_en && !nv_rd_en) else $error("memory access in boot");
    reload_a: assert property (param_reload |-> $past(cmd_wr)
        && $past(cmd_addr) == ADDR_CTRL_HI && $past(cmd_wdata) == 8'h00
        ##1 !param_reload) else $error("reload pulse wrong");
    status_rd_a: assert property (cmd_rd && cmd_addr == ADDR_CTRL_HI
        |=> cmd_rdata == {$past(boot_loader_mode),
        $past(full_access_indicator), $past(sealed_status), 5'h00})
        else $error("status byte wrong");
endmodule: flash_block_access_props

//--- sim/flash_nv_model.sv
`timescale 1ns/10ps
module flash_nv_model (
    input wire logic core_clk,
    input wire logic nv_rd_en,
    input wire logic nv_wr_en,
    input wire logic [7:0] nv_class,
    input wire logic [7:0] nv_block,
    input wire logic [4:0] nv_offset,
    input wire logic [7:0] nv_wdata,
    output logic [7:0] nv_rdata
);
    logic [7:0] mem [int];
    int key;
    initial nv_rdata = 8'h00;
    always @(posedge core_clk) begin
        key = int'({nv_class, nv_block, nv_offset});
        if (nv_rd_en === 1'b1) begin
            nv_rdata <= mem.exists(key) ? mem[key]
                : (nv_class ^ {nv_block[2:0], nv_offset} ^ 8'h5a);
        end else begin
            // Idle data flips so stale bytes never pass as fresh
            nv_rdata <= ~nv_rdata;
        end
        if (nv_wr_en === 1'b1) begin
            mem[key] = nv_wdata;
        end
    end
endmodule: flash_nv_model

//--- sim/flash_block_access_tb.sv
`timescale 1ns/10ps
module flash_block_access_tb;
    import flash_access_pkg::*;
    localparam logic [7:0] INFO_CL = 8'd58;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic [7:0] cmd_addr = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic [7:0] cmd_rdata, nv_class, nv_block, nv_wdata, nv_rdata, cl, bl;
    logic busy, nv_rd_en, nv_wr_en, param_reload, sealed_status, open_mode;
    logic full_access_indicator, boot_loader_mode;
    logic seen_reload = 1'b0;
    logic [4:0] nv_offset;
    logic [7:0] win [32];
    logic [7:0] tb_mem [int];
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    flash_block_access #(.INFO_CLASS(INFO_CL)) flash_block_access_inst (
        .core_clk(core_clk), .srst(srst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .busy(busy), .nv_rd_en(nv_rd_en), .nv_wr_en(nv_wr_en),
        .nv_class(nv_class), .nv_block(nv_block), .nv_offset(nv_offset),
        .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .param_reload(param_reload),
        .sealed_status(sealed_status), .open_mode(open_mode),
        .full_access_indicator(full_access_indicator),
        .boot_loader_mode(boot_loader_mode));
    flash_nv_model flash_nv_model_inst (.core_clk(core_clk),
        .nv_rd_en(nv_rd_en), .nv_wr_en(nv_wr_en), .nv_class(nv_class),
        .nv_block(nv_block), .nv_offset(nv_offset), .nv_wdata(nv_wdata),
        .nv_rdata(nv_rdata));
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (param_reload === 1'b1) seen_reload = 1'b1;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    function automatic logic [7:0] exp_byte(input logic [7:0] c, b,
        input logic [4:0] o);
        int k;
        k = int'({c, b, o});
        if (tb_mem.exists(k)) return tb_mem[k];
        return c ^ {b[2:0], o} ^ 8'h5a;
    endfunction: exp_byte
    function automatic logic [7:0] cks();
        logic [7:0] s;
        s = 8'h00;
        foreach (win[i]) s = s + win[i];
        return 8'hff - s;
    endfunction: cks
    task automatic chk(input logic [7:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask: chk
    task automatic wr(input logic [7:0] a, d);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
        @(posedge core_clk);
    endtask: wr
    task automatic rdc(input logic [7:0] a, exp);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge core_clk);
        cmd_rd <= 1'b0;
        @(posedge core_clk);
        chk(cmd_rdata, exp);
    endtask: rdc
    task automatic ctl(input logic [15:0] w);
        wr(ADDR_CTRL_LO, w[7:0]);
        wr(ADDR_CTRL_HI, w[15:8]);
    endtask: ctl
    task automatic idle();
        for (int i = 0; i < 100; i++) begin
            @(posedge core_clk);
            if (busy === 1'b0) break;
        end
    endtask: idle
    task automatic load(input logic [7:0] c, b, sel);
        wr(ADDR_BLOCK, sel);
        idle();
        for (int o = 0; o < WIN_BYTES; o++) begin
            win[o] = exp_byte(c, b, 5'(o));
            rdc(ADDR_WIN_BASE + 8'(o), win[o]);
        end
        rdc(ADDR_CKSUM, cks());
    endtask: load
    // Edit one random byte, then commit with a good or a bad checksum
    task automatic commit(input logic [7:0] c, b, input bit good, stores);
        logic [4:0] o;
        o = 5'($urandom_range(0, 31));
        win[o] = 8'($urandom);
        wr(ADDR_WIN_BASE + {3'h0, o}, win[o]);
        wr(ADDR_CKSUM, good ? cks() : cks() + 8'h01);
        idle();
        if (stores) foreach (win[i]) tb_mem[int'({c, b, 5'(i)})] = win[i];
    endtask: commit
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask: conclude
    initial begin
        void'($urandom(32'h3f19e6b1));
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rdc(ADDR_CTRL_HI, 8'h60);
        load(INFO_CL, 8'h00, INFO_A);
        commit(INFO_CL, 8'h00, 1'b1, 1'b0);
        load(INFO_CL, 8'h00, INFO_A);
        ctl(16'h0414);
        ctl(16'h1111);
        ctl(16'h3672);
        rdc(ADDR_CTRL_HI, 8'h60);
        $display("done: sealed access");
        ctl(16'h0414);
        ctl(16'h3672);
        rdc(ADDR_CTRL_HI, 8'h40);
        chk({7'h00, open_mode}, 8'h01);
        ctl(SUB_BOOT);
        rdc(ADDR_CTRL_HI, 8'h40);
        wr(ADDR_BAC, BAC_GENERAL);
        wr(ADDR_CLASS, INFO_CL);
        load(INFO_CL, 8'h00, 8'h00);
        for (int i = 0; i < 9; i++) begin
            cl = 8'd10 + 8'($urandom_range(0, 1));
            bl = 8'($urandom_range(0, 1));
            wr(ADDR_CLASS, cl);
            load(cl, bl, bl);
            commit(cl, bl, i % 3 != 0, i % 3 != 0);
        end
        $display("done: general access");
        wr(ADDR_BAC, 8'h01);
        load(INFO_CL, 8'h01, 8'h02);
        load(INFO_CL, 8'h02, INFO_C);
        commit(INFO_CL, 8'h02, 1'b1, 1'b1);
        load(INFO_CL, 8'h02, INFO_C);
        ctl(SUB_SEAL);
        rdc(ADDR_CTRL_HI, 8'h60);
        $display("done: info blocks and seal");
        ctl(16'h0414);
        ctl(16'h3672);
        ctl(16'hffff);
        ctl(16'hffff);
        rdc(ADDR_CTRL_HI, 8'h00);
        wr(ADDR_BAC, BAC_GENERAL);
        wr(ADDR_CLASS, 8'd112);
        load(8'd112, 8'h00, 8'h00);
        win[20] = win[20] ^ 8'h01;
        wr(ADDR_WIN_BASE + 8'd20, win[20]);
        commit(8'd112, 8'h00, 1'b1, 1'b1);
        load(8'd112, 8'h00, 8'h00);
        ctl(SUB_BOOT);
        rdc(ADDR_CTRL_HI, 8'h80);
        rdc(ADDR_WIN_BASE, 8'h00);
        ctl(SUB_RESET);
        rdc(ADDR_CTRL_HI, 8'h60);
        chk({7'h00, seen_reload}, 8'h01);
        $display("done: full access and boot");
        conclude();
    end
endmodule: flash_block_access_tb
bind flash_block_access flash_block_access_props #(
    .INFO_CLASS(INFO_CLASS), .KEY_CLASS(KEY_CLASS),
    .PRIVATE_CLASS_MIN(PRIVATE_CLASS_MIN)) flash_block_access_props_inst (
    .core_clk(core_clk), .srst(srst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .busy(busy), .nv_rd_en(nv_rd_en), .nv_wr_en(nv_wr_en),
    .nv_class(nv_class), .nv_block(nv_block), .nv_offset(nv_offset),
    .param_reload(param_reload), .sealed_status(sealed_status),
    .open_mode(open_mode), .full_access_indicator(full_access_indicator),
    .boot_loader_mode(boot_loader_mode));
